/* File: rtl/fdwg_cpu_end.sv */
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fdwg_cpu_end (
	fdwg_if.cpu bus,
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	input wire logic systemManagementMode
);
	////////////////////////////////////////////////////////////////////
	// Declarations
	fdwg_pkg::fdwg_bus_e state_r; // Bus state
	logic hph_r; // Phase toggle, matches the glue
	logic [19:0] addr_r; // Cycle address
	logic [15:0] wdata_r; // Cycle write data
	logic [3:0] ctrl_r; // Cycle kind
	logic [1:0] cfg_r; // Chip-select options
	logic pend_r; // Start requested
	logic done_r; // Sticky completion
	logic [1:0] wait_r; // Remaining wait states
	logic extSeen_r; // Glue ready seen
	logic [1:0] hold_r; // Address hold count
	logic [31:0] rdata_r;
	logic strobe_r;
	logic rdyN_r;
	logic pageSelN_r;
	logic winSelN_r;
	logic oe_r;
	logic hit0;
	logic hit1;
	logic mgmtOk;
	logic edge0;
	logic lastT2;
	logic finish;

	////////////////////////////////////////////////////////////////////
	// Chip-select decode
	// In management mode the selects fire only with the both option
	assign mgmtOk = cfg_r[fdwg_pkg::CFG_MGMT_BOTH] ||
		!systemManagementMode;
	assign hit0 = cfg_r[fdwg_pkg::CFG_CSU_EN] && mgmtOk &&
		!ctrl_r[fdwg_pkg::CTRL_MEM] &&
		(addr_r[19:1] == fdwg_pkg::PAGE_PORT[19:1]);
	assign hit1 = cfg_r[fdwg_pkg::CFG_CSU_EN] && mgmtOk &&
		ctrl_r[fdwg_pkg::CTRL_MEM] &&
		(addr_r >= fdwg_pkg::WIN_BASE) &&
		(addr_r < fdwg_pkg::WIN_END);
	// States change where the next cycle starts a new phase
	assign edge0 = !hph_r;
	assign lastT2 = cfg_r[fdwg_pkg::CFG_CSU_EN] ? (wait_r == 2'h0) :
		(extSeen_r || !bus.extReadyN);
	assign finish = (state_r == fdwg_pkg::BUS_WAIT) && edge0 && lastT2;

	////////////////////////////////////////////////////////////////////
	// Phase toggle, realigned by the glue's reset
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			hph_r <= 1'b0;
		end else begin
			hph_r <= !hph_r && !bus.cpuReset;
		end
	end

	// Bus state machine, two clocks per T1 and wait state, one for hold
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_r <= fdwg_pkg::BUS_IDLE;
		end else if (bus.cpuReset) begin
			state_r <= fdwg_pkg::BUS_IDLE;
		end else begin
			case (state_r)
				fdwg_pkg::BUS_IDLE: begin
					if (pend_r && edge0) begin
						state_r <= fdwg_pkg::BUS_T1;
					end
				end
				fdwg_pkg::BUS_T1: begin
					if (edge0) begin
						state_r <= fdwg_pkg::BUS_WAIT;
					end
				end
				fdwg_pkg::BUS_WAIT: begin
					if (finish) begin
						state_r <= fdwg_pkg::BUS_HOLD;
					end
				end
				fdwg_pkg::BUS_HOLD: begin
					// Address stays a while after strobes drop
					if (hold_r == 2'h0) begin
						state_r <= fdwg_pkg::BUS_IDLE;
					end
				end
				default: begin
					state_r <= fdwg_pkg::BUS_IDLE;
				end
			endcase
		end
	end

	// Wait-state count, ready and glue ready capture
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wait_r <= 2'h0;
			extSeen_r <= 1'b0;
			rdyN_r <= 1'b1;
		end else if (state_r == fdwg_pkg::BUS_T1) begin
			wait_r <= hit1 ? fdwg_pkg::WIN_WAITS :
				(hit0 ? fdwg_pkg::PAGE_WAITS : 2'h0);
			extSeen_r <= 1'b0;
			rdyN_r <= !(edge0 && cfg_r[fdwg_pkg::CFG_CSU_EN] &&
				!hit0 && !hit1);
		end else if (state_r == fdwg_pkg::BUS_WAIT) begin
			if (!bus.extReadyN) begin
				extSeen_r <= 1'b1;
			end
			if (edge0 && wait_r != 2'h0) begin
				wait_r <= wait_r - 2'h1;
			end
			// Ready low through the whole last wait state
			rdyN_r <= !(cfg_r[fdwg_pkg::CFG_CSU_EN] && !finish &&
				(wait_r == 2'h0 || (edge0 && wait_r == 2'h1)));
		end else begin
			rdyN_r <= 1'b1;
		end
	end

	// Strobe, selects and data drive
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			strobe_r <= 1'b0;
			pageSelN_r <= 1'b1;
			winSelN_r <= 1'b1;
			oe_r <= 1'b0;
		end else begin
			strobe_r <= (state_r == fdwg_pkg::BUS_IDLE) && pend_r &&
				edge0 && !bus.cpuReset;
			if (state_r == fdwg_pkg::BUS_T1 && edge0) begin
				strobe_r <= 1'b0;
			end else if (state_r == fdwg_pkg::BUS_T1) begin
				strobe_r <= 1'b1;
			end
			if (finish || bus.cpuReset) begin
				pageSelN_r <= 1'b1;
				winSelN_r <= 1'b1;
				oe_r <= 1'b0;
			end else if (state_r == fdwg_pkg::BUS_T1) begin
				pageSelN_r <= !hit0;
				winSelN_r <= !hit1;
				oe_r <= ctrl_r[fdwg_pkg::CTRL_WRITE];
			end
		end
	end

	// Address hold count
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			hold_r <= 2'h0;
		end else if (finish) begin
			hold_r <= fdwg_pkg::HOLD_CNT - 2'h1;
		end else if (hold_r != 2'h0) begin
			hold_r <= hold_r - 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Register writes; a start while busy is ignored
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			addr_r <= 20'h00000;
			wdata_r <= 16'h0000;
			ctrl_r <= 4'h0;
			cfg_r <= fdwg_pkg::CFG_RST;
		end else if (regWr && !pend_r) begin
			case (regAddr)
				fdwg_pkg::REG_ADDR: addr_r <= regWdata[19:0];
				fdwg_pkg::REG_WDATA: wdata_r <= regWdata[15:0];
				fdwg_pkg::REG_CTRL: ctrl_r <= regWdata[3:0];
				fdwg_pkg::REG_CFG: cfg_r <= regWdata[1:0];
				default: begin
				end
			endcase
		end
	end

	// Busy and sticky done; completion wins over a clear
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pend_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			if (regWr && regAddr == fdwg_pkg::REG_CTRL && !pend_r) begin
				pend_r <= 1'b1;
			end else if (state_r == fdwg_pkg::BUS_HOLD &&
				hold_r == 2'h0) begin
				pend_r <= 1'b0;
			end else if (bus.cpuReset && state_r == fdwg_pkg::BUS_IDLE) begin
				pend_r <= pend_r;
			end
			if (state_r == fdwg_pkg::BUS_HOLD && hold_r == 2'h0) begin
				done_r <= 1'b1;
			end else if (regWr && regAddr == fdwg_pkg::REG_STATUS &&
				regWdata[fdwg_pkg::STAT_DONE]) begin
				done_r <= 1'b0;
			end
		end
	end

	// Read data, one cycle after the strobe only
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rdata_r <= 32'h00000000;
		end else if (regRd) begin
			case (regAddr)
				fdwg_pkg::REG_ADDR: rdata_r <= {12'h000, addr_r};
				fdwg_pkg::REG_WDATA: rdata_r <= {16'h0000, wdata_r};
				fdwg_pkg::REG_CTRL: rdata_r <= {28'h0000000, ctrl_r};
				fdwg_pkg::REG_CFG: rdata_r <= {30'h00000000, cfg_r};
				fdwg_pkg::REG_STATUS: rdata_r <= {30'h00000000, done_r, pend_r};
				default: rdata_r <= 32'h00000000;
			endcase
		end else begin
			rdata_r <= 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Bus outputs, all from flops
	assign bus.addressStrobeN = !strobe_r;
	assign bus.writeNotRead = ctrl_r[fdwg_pkg::CTRL_WRITE];
	assign bus.memNotIo = ctrl_r[fdwg_pkg::CTRL_MEM];
	assign bus.readyN = rdyN_r;
	assign bus.pageRegSelectN = pageSelN_r;
	assign bus.windowSelectN = winSelN_r;
	assign bus.lowerByteEnableN = !ctrl_r[fdwg_pkg::CTRL_LOW];
	assign bus.upperByteEnableN = !ctrl_r[fdwg_pkg::CTRL_HIGH];
	assign bus.busAddr = addr_r;
	assign bus.busData = wdata_r;
	assign bus.busDataOe = oe_r;
	assign regRdata = rdata_r;
endmodule : fdwg_cpu_end
`default_nettype wire

/* File: rtl/fdwg_pkg.sv */
package fdwg_pkg;
	// Clock and flash timing, cycle counts derived from the rate
	localparam int CLK_PERIOD_NS = 20;
	localparam int FLASH_FLOAT_NS = 30;
	localparam int ADDR_HOLD_NS = 10;
	// Least times round up to whole cycles
	localparam int FLOAT_CYC = (FLASH_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] FLOAT_CNT = 2'(FLOAT_CYC);
	localparam logic [1:0] HOLD_CNT = 2'(HOLD_CYC);

	// Page register and window map
	localparam int PAGE_W = 8;
	localparam int PAGE_COUNT = 256;
	localparam int PAGE_BYTES = 16384;
	localparam logic [19:0] PAGE_PORT = 20'h003e0;
	localparam logic [19:0] WIN_BASE = 20'hc8000;
	localparam logic [19:0] WIN_END = 20'hcc000;
	localparam logic [19:0] ADAPTER_LO = 20'hc0000;
	localparam logic [19:0] ADAPTER_HI = 20'hf0000;
	localparam logic [PAGE_W-1:0] PAGE_RST = 8'h00;

	// Wait states of the two chip-select regions
	localparam logic [1:0] PAGE_WAITS = 2'h1;
	localparam logic [1:0] WIN_WAITS = 2'h2;

	// Controller register offsets
	localparam logic [7:0] REG_ADDR = 8'h00;
	localparam logic [7:0] REG_WDATA = 8'h04;
	localparam logic [7:0] REG_CTRL = 8'h08;
	localparam logic [7:0] REG_CFG = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	// Control word fields
	localparam int CTRL_WRITE = 0;
	localparam int CTRL_MEM = 1;
	localparam int CTRL_LOW = 2;
	localparam int CTRL_HIGH = 3;
	// Config fields and reset value
	localparam int CFG_CSU_EN = 0;
	localparam int CFG_MGMT_BOTH = 1;
	localparam logic [1:0] CFG_RST = 2'h3;
	// Status fields
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;

	// Processor bus states
	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_T1,
		BUS_WAIT,
		BUS_HOLD
	} fdwg_bus_e;
endpackage : fdwg_pkg

/* File: rtl/fdwg_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface fdwg_if;
	// Processor local bus
	logic addressStrobeN;
	logic writeNotRead;
	logic memNotIo;
	logic readyN;
	logic pageRegSelectN;
	logic windowSelectN;
	logic upperByteEnableN;
	logic lowerByteEnableN;
	logic [19:0] busAddr;
	logic [15:0] busData;
	logic busDataOe;
	// Glue outputs
	logic extReadyN;
	logic cpuReset;
	logic flashWriteN;
	logic bufferEnableN;
	logic latchClock;
	logic latchOutputControlN;
	logic [7:0] flashUpperAddr;
	logic flashUpperAddrOe;
	logic highLaneChipEnableN;
	logic lowLaneChipEnableN;
	logic flashPowerdownN;

	modport glue(
		input addressStrobeN, writeNotRead, memNotIo, readyN,
		input pageRegSelectN, windowSelectN, upperByteEnableN,
		input lowerByteEnableN, busAddr, busData, busDataOe,
		output extReadyN, cpuReset, flashWriteN, bufferEnableN,
		output latchClock, latchOutputControlN, flashUpperAddr,
		output flashUpperAddrOe, highLaneChipEnableN,
		output lowLaneChipEnableN, flashPowerdownN
	);
	modport cpu(
		output addressStrobeN, writeNotRead, memNotIo, readyN,
		output pageRegSelectN, windowSelectN, upperByteEnableN,
		output lowerByteEnableN, busAddr, busData, busDataOe,
		input extReadyN, cpuReset
	);
endinterface : fdwg_if
`default_nettype wire

/* File: rtl/fdwg_glue_end.sv */
`timescale 1ns/1ps
`default_nettype none
module fdwg_glue_end (
	fdwg_if.glue bus,
	input wire logic mclk,
	input wire logic rstn,
	input wire logic powerGood,
	input wire logic decodeEnable,
	output logic [7:0] pageValue
);
	////////////////////////////////////////////////////////////////////
	// Declarations
	logic pgMeta_r; // First synchroniser stage
	logic pgSync_r; // Second synchroniser stage
	logic reset_r; // Processor reset
	logic flashUpN_r; // Flash power-down release
	logic phase_r; // Bus phase toggle
	logic t21_r; // First wait phase
	logic t22_r; // Second wait phase
	logic we_r; // Flash write strobe, active high
	logic en_r; // Buffer enable, active high
	logic enNxt;
	logic latch_r; // Latch clock pulse
	logic hiLane_r; // High lane enable, active high
	logic loLane_r; // Low lane enable, active high
	logic oe_r; // Upper address drive
	logic [7:0] windowPageSelect_r; // Page register
	logic [7:0] upper_r; // Page as driven to flash
	logic [1:0] gap_r; // Turnaround hold-off
	logic extReady_r; // Own ready, active high
	logic addrStrobe;
	logic ownPageSel;
	logic ownWinSel;
	logic pageSel;
	logic winSel;
	logic ready;

	////////////////////////////////////////////////////////////////////
	// Selects and decode
	// Own decode stands in when no chip-selects are spare
	assign ownPageSel = !bus.memNotIo &&
		(bus.busAddr[19:1] == fdwg_pkg::PAGE_PORT[19:1]);
	assign ownWinSel = bus.memNotIo &&
		(bus.busAddr >= fdwg_pkg::WIN_BASE) &&
		(bus.busAddr < fdwg_pkg::WIN_END);
	// Pin selects come from the processor on this clock
	assign pageSel = decodeEnable ? ownPageSel : !bus.pageRegSelectN;
	assign winSel = decodeEnable ? ownWinSel : !bus.windowSelectN;
	assign addrStrobe = !bus.addressStrobeN;
	assign ready = !bus.readyN || extReady_r;

	////////////////////////////////////////////////////////////////////
	// Power-good synchroniser; pin is asynchronous to mclk
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pgMeta_r <= 1'b0;
			pgSync_r <= 1'b0;
		end else begin
			pgMeta_r <= powerGood;
			pgSync_r <= pgMeta_r;
		end
	end

	// Processor reset follows power-good; flash held down with it
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			reset_r <= 1'b1;
			flashUpN_r <= 1'b0;
		end else begin
			reset_r <= !pgSync_r;
			flashUpN_r <= pgSync_r;
		end
	end

	// Phase toggle; reset forces it low so it matches the processor
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			phase_r <= 1'b0;
		end else begin
			phase_r <= !phase_r && !reset_r;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Wait phase trackers, two clocks each
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			t21_r <= 1'b0;
			t22_r <= 1'b0;
		end else begin
			t21_r <= (!phase_r && addrStrobe) || (phase_r && t21_r);
			t22_r <= (!phase_r && t21_r) || (phase_r && t22_r);
		end
	end

	// Write strobe covers only the first two wait states, so it rises
	// half a state before ready ends and address hold is kept
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			we_r <= 1'b0;
		end else begin
			we_r <= winSel && bus.writeNotRead && (t21_r || t22_r);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Buffer enable
	// Held until ready at the end of a state, so an early ready
	// still leaves the buffer on for the second half
	always_comb begin
		enNxt = winSel && ((t21_r && (gap_r == 2'h0)) ||
			(en_r && !(ready && !phase_r)));
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			en_r <= 1'b0;
		end else begin
			en_r <= enNxt;
		end
	end

	// Hold-off after the buffer closes; flash needs time to float
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			gap_r <= 2'h0;
		end else if (en_r && !enNxt) begin
			gap_r <= fdwg_pkg::FLOAT_CNT;
		end else if (gap_r != 2'h0) begin
			gap_r <= gap_r - 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Page latch pulse, second half of the first wait state only
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			latch_r <= 1'b0;
		end else begin
			latch_r <= pageSel && bus.writeNotRead && t21_r &&
				phase_r;
		end
	end

	// Page register; a trade-off: reset to zero, yet software must
	// still write a page before the first window access
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			windowPageSelect_r <= fdwg_pkg::PAGE_RST;
		end else if (latch_r) begin
			windowPageSelect_r <=
				bus.busData[fdwg_pkg::PAGE_W-1:0];
		end
	end

	// Upper address drive follows window select
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			oe_r <= 1'b0;
			upper_r <= fdwg_pkg::PAGE_RST;
		end else begin
			oe_r <= winSel;
			upper_r <= windowPageSelect_r;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Lane chip enables; nothing outside the window
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			hiLane_r <= 1'b0;
			loLane_r <= 1'b0;
		end else begin
			hiLane_r <= winSel && !bus.upperByteEnableN;
			loLane_r <= winSel && !bus.lowerByteEnableN;
		end
	end

	// Own ready for self-decoded cycles, second half of second wait
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			extReady_r <= 1'b0;
		end else begin
			extReady_r <= decodeEnable && (ownPageSel || ownWinSel) &&
				t22_r && phase_r && !extReady_r;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs, all from flops
	assign bus.cpuReset = reset_r;
	assign bus.flashPowerdownN = flashUpN_r;
	assign bus.flashWriteN = !we_r;
	assign bus.bufferEnableN = !en_r;
	assign bus.latchClock = latch_r;
	assign bus.latchOutputControlN = !oe_r;
	assign bus.flashUpperAddrOe = oe_r;
	assign bus.flashUpperAddr = upper_r;
	assign bus.highLaneChipEnableN = !hiLane_r;
	assign bus.lowLaneChipEnableN = !loLane_r;
	assign bus.extReadyN = !extReady_r;
	assign pageValue = windowPageSelect_r;
endmodule : fdwg_glue_end
`default_nettype wire

/* File: tb/fdwg_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the glue end's outputs across the shared bus
module fdwg_chk (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic writeNotRead,
	input wire logic readyN,
	input wire logic pageRegSelectN,
	input wire logic windowSelectN,
	input wire logic upperByteEnableN,
	input wire logic lowerByteEnableN,
	input wire logic cpuReset,
	input wire logic flashWriteN,
	input wire logic bufferEnableN,
	input wire logic latchClock,
	input wire logic latchOutputControlN,
	input wire logic highLaneChipEnableN,
	input wire logic lowLaneChipEnableN,
	input wire logic flashPowerdownN
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	////////////////////////////////////////
	// Lane enables lag the select by one flop
	AST_LANE_OFF: assert property ($past(windowSelectN) |->
		highLaneChipEnableN && lowLaneChipEnableN)
		else $error("lane enable without window select");
	AST_LANE_MATCH: assert property (!$past(windowSelectN) |->
		highLaneChipEnableN == $past(upperByteEnableN) &&
		lowLaneChipEnableN == $past(lowerByteEnableN))
		else $error("lane enable does not follow byte enable");
	// Write strobe only for window writes, three or four cycles long
	AST_WE_CAUSE: assert property (!flashWriteN |->
		writeNotRead && !windowSelectN)
		else $error("write strobe outside a window write");
	AST_WE_SPAN: assert property ($fell(flashWriteN) |->
		!flashWriteN[*3] ##[1:2] $rose(flashWriteN))
		else $error("write strobe length wrong");
	// Strobe must already be high in the second half of the last state
	AST_WE_EARLY: assert property (!readyN && !$past(readyN) |->
		flashWriteN)
		else $error("write strobe still low at cycle end");
	// Buffer stays open through the second half of the last state
	AST_BUF_HOLD: assert property (!readyN && !$past(readyN) &&
		!windowSelectN |-> !bufferEnableN)
		else $error("buffer closed before cycle end");
	AST_LATCH_ONE: assert property (latchClock |=> !latchClock)
		else $error("latch pulse longer than one cycle");
	AST_LATCH_CAUSE: assert property (latchClock |->
		!pageRegSelectN && writeNotRead)
		else $error("latch pulse without page write");
	AST_PAGE_DRIVE: assert property (
		latchOutputControlN == $past(windowSelectN))
		else $error("page output control not tracking select");
	AST_BUF_SEL: assert property (!bufferEnableN |->
		!$past(windowSelectN))
		else $error("buffer open without window select");
	// Flash needs time to float its lines before the buffer reopens
	AST_BUF_FLOAT: assert property ($rose(bufferEnableN) |->
		bufferEnableN[*3])
		else $error("buffer reopened too soon");
	AST_RESET: assert property (!flashPowerdownN |-> cpuReset)
		else $error("processor out of reset without power good");
	////////////////////////////////////////
	COV_WE: cover property ($fell(flashWriteN));
	COV_LATCH: cover property (latchClock);
	COV_READ: cover property ($fell(bufferEnableN) && !writeNotRead);
endmodule : fdwg_chk
`default_nettype wire

/* File: tb/tb_flash_disk_window_glue.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_flash_disk_window_glue;
	logic mclk;
	logic rstn;
	logic powerGood;
	logic decodeEnable; // Held low: pin selects carry the decode
	logic systemManagementMode;
	logic [7:0] regAddr;
	logic [31:0] regWdata;
	logic regWr;
	logic regRd;
	logic [31:0] regRdata;
	logic [7:0] pageValue;
	logic [31:0] seed; // Xorshift state
	logic [31:0] r;
	logic [7:0] expPage; // Model of the page register
	logic [1:0] lanes;
	logic monOn;
	// Counts: strobe, latch, high CE, low CE, buffer, page out, bad page
	int cnt[7];
	string nm[6] = '{"we", "latch", "hiCe", "loCe", "buf", "pageOut"};
	int n_fail;
	int total_checks;
	fdwg_if link ();
	fdwg_glue_end u_fdwg_glue_end (.bus(link), .mclk(mclk), .rstn(rstn),
		.powerGood(powerGood), .decodeEnable(decodeEnable),
		.pageValue(pageValue));
	fdwg_cpu_end u_fdwg_cpu_end (.bus(link), .mclk(mclk), .rstn(rstn),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata),
		.systemManagementMode(systemManagementMode));
	fdwg_chk u_fdwg_chk (.mclk(mclk), .rstn(rstn),
		.writeNotRead(link.writeNotRead), .readyN(link.readyN),
		.pageRegSelectN(link.pageRegSelectN),
		.windowSelectN(link.windowSelectN),
		.upperByteEnableN(link.upperByteEnableN),
		.lowerByteEnableN(link.lowerByteEnableN),
		.cpuReset(link.cpuReset), .flashWriteN(link.flashWriteN),
		.bufferEnableN(link.bufferEnableN), .latchClock(link.latchClock),
		.latchOutputControlN(link.latchOutputControlN),
		.highLaneChipEnableN(link.highLaneChipEnableN),
		.lowLaneChipEnableN(link.lowLaneChipEnableN),
		.flashPowerdownN(link.flashPowerdownN));
	////////////////////////////////////////
	// 50 MHz clock
	always #10 mclk = ~mclk;
	// Tally flash side activity while an operation is open
	always @(posedge mclk) begin
		if (!monOn) begin
			cnt = '{default: 0};
		end else begin
			cnt[0] += int'(!link.flashWriteN);
			cnt[1] += int'(link.latchClock);
			cnt[2] += int'(!link.highLaneChipEnableN);
			cnt[3] += int'(!link.lowLaneChipEnableN);
			cnt[4] += int'(!link.bufferEnableN);
			cnt[5] += int'(link.flashUpperAddrOe === 1'h1);
			// Upper address must carry the page last written
			cnt[6] += int'(link.flashUpperAddrOe === 1'h1 &&
				link.flashUpperAddr !== expPage);
		end
	end
	////////////////////////////////////////
	function automatic logic [31:0] next_rand();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : next_rand
	task automatic chk_val(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask : chk_val
	// Write strobe is left high so writes may follow back to back
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'h1;
		regRd <= 1'h0;
		@(posedge mclk);
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		regAddr <= a;
		regWr <= 1'h0;
		regRd <= 1'h1;
		@(posedge mclk);
		regRd <= 1'h0;
		@(posedge mclk);
		d = regRdata;
	endtask : reg_rd
	// One processor bus cycle; e lists the expected flash side activity
	task automatic run_op(input logic [19:0] a, input logic [15:0] d,
		input logic [3:0] c, input logic [5:0] e);
		logic [31:0] s;
		s = 32'h0;
		monOn <= 1'h1;
		reg_wr(fdwg_pkg::REG_ADDR, {12'h000, a});
		reg_wr(fdwg_pkg::REG_WDATA, {16'h0000, d});
		reg_wr(fdwg_pkg::REG_CTRL, {28'h0000000, c});
		// Bounded poll: the slowest cycle is about eleven clocks
		for (int i = 0; i < 40 && s[fdwg_pkg::STAT_DONE] !== 1'h1; i++) begin
			reg_rd(fdwg_pkg::REG_STATUS, s);
		end
		chk_val("done", 32'h1, {31'h0, s[fdwg_pkg::STAT_DONE]});
		reg_wr(fdwg_pkg::REG_STATUS, 32'h2);
		for (int k = 0; k < 6; k++) begin
			chk_val(nm[k], {31'h0, e[k]},
				k == 1 ? 32'(cnt[1]) : {31'h0, cnt[k] != 0});
		end
		chk_val("pageBad", 32'h0, 32'(cnt[6]));
		regWr <= 1'h0;
		monOn <= 1'h0;
		@(posedge mclk);
	endtask : run_op
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : give_verdict
	////////////////////////////////////////
	// Cut a hang short; the whole run needs a few hundred clocks
	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		$display("BAD watchdog exp done got hang");
		give_verdict();
	end
	initial begin
		mclk = 1'h0;
		rstn = 1'h0;
		powerGood = 1'h0;
		decodeEnable = 1'h0;
		systemManagementMode = 1'h0;
		regAddr = 8'h00;
		regWdata = 32'h0;
		regWr = 1'h0;
		regRd = 1'h0;
		seed = 32'h11;
		expPage = 8'h00;
		monOn = 1'h0;
		repeat (4) @(posedge mclk);
		rstn <= 1'h1;
		@(posedge mclk);
		chk_val("cpuReset", 32'h1, {31'h0, link.cpuReset});
		chk_val("powerdown", 32'h0, {31'h0, link.flashPowerdownN});
		powerGood <= 1'h1;
		repeat (4) @(posedge mclk);
		chk_val("cpuReset", 32'h0, {31'h0, link.cpuReset});
		reg_rd(fdwg_pkg::REG_CFG, r);
		chk_val("cfg", 32'(fdwg_pkg::CFG_RST), r);
		reg_rd(8'h20, r);
		chk_val("unmapped", 32'h0, r);
		// Window placement must sit inside the adapter region
		r = 32'(fdwg_pkg::WIN_BASE >= fdwg_pkg::ADAPTER_LO &&
			fdwg_pkg::WIN_END <= fdwg_pkg::ADAPTER_HI);
		chk_val("adapter", 32'h1, r);
		// Page writes, then every lane mix read and written in the window
		for (int i = 0; i < 3; i++) begin
			r = next_rand();
			expPage = r[7:0];
			run_op(fdwg_pkg::PAGE_PORT, r[15:0], 4'h1, 6'h02);
			chk_val("page", {24'h0, expPage}, {24'h0, pageValue});
			for (int k = 0; k < 6; k++) begin
				lanes = 2'(k % 3 + 1);
				r = next_rand();
				r[19:0] = k == 5 ? fdwg_pkg::WIN_END - 20'h2 :
					fdwg_pkg::WIN_BASE + (r[19:0] & 20'h03ffe);
				run_op(r[19:0], r[31:16], {lanes, 1'h1, k < 3},
					{2'h3, lanes[0], lanes[1], 1'h0, k < 3});
			end
		end
		// Window write in management mode: allowed, then refused
		systemManagementMode <= 1'h1;
		run_op(fdwg_pkg::WIN_BASE, 16'h1234, 4'hf, 6'h3d);
		reg_wr(fdwg_pkg::REG_CFG, 32'h1);
		run_op(fdwg_pkg::WIN_BASE, 16'h1234, 4'hf, 6'h00);
		reg_wr(fdwg_pkg::REG_CFG, 32'h3);
		systemManagementMode <= 1'h0;
		// Just outside the window and beside the page port
		run_op(fdwg_pkg::WIN_END, 16'h5a5a, 4'hf, 6'h00);
		run_op(fdwg_pkg::WIN_BASE - 20'h2, 16'ha5a5, 4'hf, 6'h00);
		run_op(fdwg_pkg::PAGE_PORT + 20'h2, 16'h00ff, 4'h1, 6'h00);
		chk_val("page", {24'h0, expPage}, {24'h0, pageValue});
		give_verdict();
	end
endmodule : tb_flash_disk_window_glue
`default_nettype wire
